// file: hw/rta_host.sv
// controller that programs the rtc alarm block on behalf of software
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module rta_host (
  input  wire logic        clk,       // 40 MHz clock
  input  wire logic        rst_n,     // sync reset, low
  rta_if.host              bus,       // device register bus
  input  wire logic [2:0]  sw_addr,   // software register index
  input  wire logic [15:0] sw_wdata,  // software write data
  input  wire logic        sw_wr,     // software write strobe
  input  wire logic        sw_rd,     // software read strobe
  output logic [15:0]      sw_rdata   // read data, cycle after sw_rd
);

  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,
    ST_WR_C1 = 11'h002,
    ST_WR_C2 = 11'h004,
    ST_WR_YA = 11'h008,
    ST_RD_YA = 11'h010,
    ST_CK_YA = 11'h020,
    ST_WR_YC = 11'h040,
    ST_RD_C1 = 11'h080,
    ST_CK_C1 = 11'h100,
    ST_CLR_C = 11'h200,
    ST_RD_YC = 11'h400
  } rta_state_t;

  rta_state_t  state_r;
  rta_state_t  state_nxt;
  logic [7:0]  c1_r;
  logic [7:0]  c2_r;
  logic [15:0] ya_r;
  logic        yen_r;
  logic        bcd_err_r;
  logic        verify_err_r;
  logic        retried_r;
  logic [15:0] sw_rdata_r;
  logic [1:0]  addr_r;
  logic [15:0] wdata_r;
  logic        wr_r;
  logic        rd_r;
  logic [1:0]  addr_nxt;
  logic [15:0] wdata_nxt;
  logic        wr_nxt;
  logic        rd_nxt;
  logic        cmd_wr;
  logic        ya_bad;

  // ------------------------------------------------------------
  // command decode and bcd range check
  // ------------------------------------------------------------
  assign cmd_wr = sw_wr && (sw_addr == rta_pkg::HOFS_CMD) && (state_r == ST_IDLE);
  // any digit above nine puts the alarm outside 0000..9999
  assign ya_bad = (ya_r[15:12] > rta_pkg::BCD_MAX) || (ya_r[11:8] > rta_pkg::BCD_MAX)
               || (ya_r[7:4] > rta_pkg::BCD_MAX) || (ya_r[3:0] > rta_pkg::BCD_MAX);

  // ------------------------------------------------------------
  // software-side registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      c1_r  <= rta_pkg::RST_CTRL_ONE;
      c2_r  <= rta_pkg::RST_CTRL_TWO;
      ya_r  <= 16'h0000;
      yen_r <= 1'b0;
    end
    else if (sw_wr && state_r == ST_IDLE)
    begin
      case (sw_addr)
        rta_pkg::HOFS_C1: c1_r  <= sw_wdata[7:0];
        rta_pkg::HOFS_C2: c2_r  <= sw_wdata[7:0];
        rta_pkg::HOFS_YA: ya_r  <= sw_wdata;
        rta_pkg::HOFS_YC: yen_r <= sw_wdata[rta_pkg::BIT_YEAR_EN];
        default:          ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // init order: control one, control two with divider reset, then the
  // rest; a carry seen after the sequence clears it and goes back to the year alarm write
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (cmd_wr && !ya_bad)
        begin
          if (sw_wdata[rta_pkg::CMD_INIT])
            state_nxt = ST_WR_C1;
          else if (sw_wdata[rta_pkg::CMD_ARM])
            state_nxt = ST_WR_YA;
        end
      ST_WR_C1: state_nxt = ST_WR_C2;
      ST_WR_C2: state_nxt = ST_WR_YA;
      ST_WR_YA: state_nxt = ST_RD_YA;
      ST_RD_YA: state_nxt = ST_CK_YA;
      ST_CK_YA: state_nxt = ST_WR_YC;
      ST_WR_YC: state_nxt = ST_RD_YC;
      ST_RD_YC: state_nxt = ST_RD_C1;
      ST_RD_C1: state_nxt = ST_CK_C1;
      ST_CK_C1:
        if (bus.rdata[rta_pkg::BIT_CARRY_FLAG])
          state_nxt = ST_CLR_C;
        else
          state_nxt = ST_IDLE;
      ST_CLR_C: state_nxt = ST_WR_YA;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // ------------------------------------------------------------
  // bus cycle for the state being entered
  // ------------------------------------------------------------
  always_comb
  begin
    addr_nxt  = rta_pkg::OFS_CTRL_ONE;
    wdata_nxt = 16'h0000;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    case (state_nxt)
      ST_WR_C1:
      begin
        wr_nxt    = 1'b1;
        wdata_nxt = {8'h00, c1_r};
      end
      ST_WR_C2:
      begin
        wr_nxt    = 1'b1;
        addr_nxt  = rta_pkg::OFS_CTRL_TWO;
        wdata_nxt = {8'h00, c2_r} | (16'h0001 << rta_pkg::BIT_DIV_RESET);
      end
      ST_WR_YA:
      begin
        wr_nxt    = 1'b1;
        addr_nxt  = rta_pkg::OFS_YEAR_ALRM;
        wdata_nxt = ya_r;
      end
      ST_RD_YA:
      begin
        rd_nxt   = 1'b1;
        addr_nxt = rta_pkg::OFS_YEAR_ALRM;
      end
      ST_WR_YC:
      begin
        wr_nxt    = 1'b1;
        addr_nxt  = rta_pkg::OFS_YEAR_CTL;
        wdata_nxt = {8'h00, yen_r, 7'h00};
      end
      ST_RD_YC:
      begin
        // year control read back, reserved bits must come back zero
        rd_nxt   = 1'b1;
        addr_nxt = rta_pkg::OFS_YEAR_CTL;
      end
      ST_RD_C1:
        rd_nxt = 1'b1;
      ST_CLR_C:
      begin
        // carry cleared, alarm flag written 1 so it is left alone
        wr_nxt    = 1'b1;
        wdata_nxt = {8'h00, 1'b0, c1_r[6:1], 1'b1};
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_r  <= rta_pkg::OFS_CTRL_ONE;
      wdata_r <= 16'h0000;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
    end
    else
    begin
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bcd_err_r    <= 1'b0;
      verify_err_r <= 1'b0;
      retried_r    <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
      begin
        bcd_err_r    <= ya_bad;
        verify_err_r <= 1'b0;
        retried_r    <= 1'b0;
      end
      if (state_r == ST_CK_YA && bus.rdata != ya_r)
        verify_err_r <= 1'b1;
      if (state_r == ST_CLR_C)
        retried_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // software read port
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sw_rdata_r <= 16'h0000;
    else if (sw_rd)
    begin
      case (sw_addr)
        rta_pkg::HOFS_C1:     sw_rdata_r <= {8'h00, c1_r};
        rta_pkg::HOFS_C2:     sw_rdata_r <= {8'h00, c2_r};
        rta_pkg::HOFS_YA:     sw_rdata_r <= ya_r;
        rta_pkg::HOFS_YC:     sw_rdata_r <= {8'h00, yen_r, 7'h00};
        rta_pkg::HOFS_STATUS:
          sw_rdata_r <= {9'h000, verify_err_r, bus.carry_irq, bus.periodic_irq,
                         bus.alarm_irq, retried_r, bcd_err_r, state_r != ST_IDLE};
        default:              sw_rdata_r <= 16'h0000;
      endcase
    end
  end

  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr    = wr_r;
  assign bus.rd    = rd_r;
  assign sw_rdata  = sw_rdata_r;

endmodule // rta_host

// file: hw/rta_pkg.sv
// shared constants for the rtc alarm and interrupt block and its controller
package rta_pkg;
  // ------------------------------------------------------------
  // device register indices (word index on the device bus)
  // ------------------------------------------------------------
  localparam logic [1:0] OFS_CTRL_ONE  = 2'h0;
  localparam logic [1:0] OFS_CTRL_TWO  = 2'h1;
  localparam logic [1:0] OFS_YEAR_CTL  = 2'h2;
  localparam logic [1:0] OFS_YEAR_ALRM = 2'h3;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CARRY_FLAG  = 7;
  localparam int BIT_CARRY_IE    = 4;
  localparam int BIT_ALARM_IE    = 3;
  localparam int BIT_ALARM_FLAG  = 0;
  localparam int BIT_PERIOD_FLAG = 7;
  localparam int BIT_PSEL_HI     = 6;
  localparam int BIT_PSEL_LO     = 4;
  localparam int BIT_OSC_EN      = 3;
  localparam int BIT_ADJUST      = 2;
  localparam int BIT_DIV_RESET   = 1;
  localparam int BIT_START       = 0;
  localparam int BIT_YEAR_EN     = 7;
  // ------------------------------------------------------------
  // reset values and widths
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h09;
  localparam logic [7:0] RST_YEAR_CTL = 8'h00;
  localparam int         DATA_W       = 16;
  localparam int         NUM_FIELDS   = 6;
  localparam int         NUM_PERIODS  = 7;
  localparam logic [3:0] BCD_MAX      = 4'h9;
  // ------------------------------------------------------------
  // controller software register indices
  // ------------------------------------------------------------
  localparam logic [2:0] HOFS_C1     = 3'h0;
  localparam logic [2:0] HOFS_C2     = 3'h1;
  localparam logic [2:0] HOFS_YA     = 3'h2;
  localparam logic [2:0] HOFS_YC     = 3'h3;
  localparam logic [2:0] HOFS_CMD    = 3'h4;
  localparam logic [2:0] HOFS_STATUS = 3'h5;
  localparam int         CMD_INIT    = 0;
  localparam int         CMD_ARM     = 1;
endpackage

// file: hw/rta_if.sv
// register bus and interrupt lines between controller and rtc alarm block
`timescale 1ns/1ps
interface rta_if;
  logic [1:0]  addr;          // register index
  logic [15:0] wdata;         // write data
  logic        wr;            // write strobe
  logic        rd;            // read strobe
  logic [15:0] rdata;         // read data, cycle after rd
  logic        alarm_irq;     // alarm request level
  logic        periodic_irq;  // periodic request level
  logic        carry_irq;     // carry request level

  modport dev  (input addr, wdata, wr, rd,
                output rdata, alarm_irq, periodic_irq, carry_irq);
  modport host (output addr, wdata, wr, rd,
                input rdata, alarm_irq, periodic_irq, carry_irq);
endinterface

// file: hw/rta_dev.sv
// rtc alarm compare, flags and interrupt request logic
//
// Summary of operation
// - year enable set: compare year counter too
// - flag only when all enabled fields match
// - software keeps year alarm within 0000..9999
// - year alarm is four bcd digits
// - power-on reset clears year compare control
// - year alarm keeps contents through resets
// - carry during write: check flag, rewrite
// - repeat time read after a carry
// - arm: enable participating fields, disable others
// - alarm flag resets while match persists
// - alarm request is flag and enable
// - periodic request needs nonzero select, flag
// - carry request is flag and enable
// - init: control one, divider reset, rest
// - flag events near standby wake may drop
// - counter write: block, write, read back
// - select 001..111 picks 1/256s to 2s
// - alarm flag: write 0 clears, 1 ignored
`timescale 1ns/1ps
module rta_dev #(
  parameter int NFIELD = rta_pkg::NUM_FIELDS  // other alarm fields
) (
  input  wire logic              clk,           // 40 MHz clock
  input  wire logic              rst_n,         // power-on reset, sync, low
  rta_if.dev                     bus,           // register bus and requests
  input  wire logic [15:0]       year_counter,  // bcd year count
  input  wire logic [NFIELD-1:0] field_enable,  // per-field compare enables
  input  wire logic [NFIELD-1:0] field_match,   // per-field counter equals alarm
  input  wire logic              carry_event,   // one-cycle counter carry pulse
  input  wire logic [6:0]        period_tick,   // pulses: 1/256s .. 2s
  output logic                   osc_enable,    // oscillator run level
  output logic                   count_start,   // counters run level
  output logic                   divider_reset, // one-cycle divider reset
  output logic                   adjust_pulse   // one-cycle 30 s adjust
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic        alarm_flag_r;
  logic        carry_flag_r;
  logic        alarm_irq_enable_r;
  logic        carry_irq_enable_r;
  logic        periodic_flag_r;
  logic [2:0]  period_select_r;
  logic        year_compare_enable_r;
  logic [15:0] year_alarm_value_r;
  logic        osc_enable_r;
  logic        count_start_r;
  logic        divider_reset_r;
  logic        adjust_pulse_r;
  logic [15:0] rdata_r;
  logic        alarm_irq_r;
  logic        periodic_irq_r;
  logic        carry_irq_r;

  logic        wr_c1;
  logic        wr_c2;
  logic        wr_yc;
  logic        wr_ya;
  logic        year_ok;
  logic        fields_ok;
  logic        any_enabled;
  logic        alarm_match;
  logic        period_hit;
  logic [2:0]  psel_idx;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign wr_c1 = bus.wr && (bus.addr == rta_pkg::OFS_CTRL_ONE);
  assign wr_c2 = bus.wr && (bus.addr == rta_pkg::OFS_CTRL_TWO);
  assign wr_yc = bus.wr && (bus.addr == rta_pkg::OFS_YEAR_CTL);
  assign wr_ya = bus.wr && (bus.addr == rta_pkg::OFS_YEAR_ALRM);

  // ------------------------------------------------------------
  // alarm comparison
  // ------------------------------------------------------------
  // year takes part only when its enable is set; the whole 16-bit bcd
  // word is compared digit for digit, so an out-of-range alarm simply
  // never matches a legal counter
  assign year_ok = !year_compare_enable_r
                   || (year_counter == year_alarm_value_r);
  // a disabled field is a don't-care
  assign fields_ok   = &(~field_enable | field_match);
  // with nothing enabled there is no alarm at all
  assign any_enabled = (|field_enable) || year_compare_enable_r;
  assign alarm_match = any_enabled && fields_ok && year_ok;

  // ------------------------------------------------------------
  // periodic tick selection
  // ------------------------------------------------------------
  assign psel_idx   = period_select_r - 3'h1;
  // select 000 picks no tick, 001..111 pick taps 0..6
  assign period_hit = (period_select_r != 3'h0) && period_tick[psel_idx];

  // ------------------------------------------------------------
  // alarm flag
  // ------------------------------------------------------------
  // a live match wins over a software clear in the same cycle, so the
  // flag stays set while the fields still match
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      alarm_flag_r <= 1'b0;
    else if (alarm_match)
      alarm_flag_r <= 1'b1;
    else if (wr_c1 && !bus.wdata[rta_pkg::BIT_ALARM_FLAG])
      alarm_flag_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // carry flag
  // ------------------------------------------------------------
  // software rewrites the counters when it sees this set after a write;
  // the carry pulse wins over a clear so no carry is ever lost here
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carry_flag_r <= 1'b0;
    else if (carry_event)
      carry_flag_r <= 1'b1;
    else if (wr_c1)
      carry_flag_r <= bus.wdata[rta_pkg::BIT_CARRY_FLAG];
  end

  // ------------------------------------------------------------
  // control one enables
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alarm_irq_enable_r <= rta_pkg::RST_CTRL_ONE[rta_pkg::BIT_ALARM_IE];
      carry_irq_enable_r <= rta_pkg::RST_CTRL_ONE[rta_pkg::BIT_CARRY_IE];
    end
    else if (wr_c1)
    begin
      alarm_irq_enable_r <= bus.wdata[rta_pkg::BIT_ALARM_IE];
      carry_irq_enable_r <= bus.wdata[rta_pkg::BIT_CARRY_IE];
    end
  end

  // ------------------------------------------------------------
  // periodic flag
  // ------------------------------------------------------------
  // the tick wins over a clear written in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      periodic_flag_r <= 1'b0;
    else if (period_hit)
      periodic_flag_r <= 1'b1;
    else if (wr_c2)
      periodic_flag_r <= bus.wdata[rta_pkg::BIT_PERIOD_FLAG];
  end

  // ------------------------------------------------------------
  // control two fields and divider strobes
  // ------------------------------------------------------------
  // divider reset and adjust are self-clearing strobes, never stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      period_select_r <= rta_pkg::RST_CTRL_TWO[rta_pkg::BIT_PSEL_HI:rta_pkg::BIT_PSEL_LO];
      osc_enable_r    <= rta_pkg::RST_CTRL_TWO[rta_pkg::BIT_OSC_EN];
      count_start_r   <= rta_pkg::RST_CTRL_TWO[rta_pkg::BIT_START];
      divider_reset_r <= 1'b0;
      adjust_pulse_r  <= 1'b0;
    end
    else
    begin
      divider_reset_r <= wr_c2 && bus.wdata[rta_pkg::BIT_DIV_RESET];
      adjust_pulse_r  <= wr_c2 && bus.wdata[rta_pkg::BIT_ADJUST];
      if (wr_c2)
      begin
        period_select_r <= bus.wdata[rta_pkg::BIT_PSEL_HI:rta_pkg::BIT_PSEL_LO];
        osc_enable_r    <= bus.wdata[rta_pkg::BIT_OSC_EN];
        count_start_r   <= bus.wdata[rta_pkg::BIT_START];
      end
    end
  end

  // ------------------------------------------------------------
  // year compare control
  // ------------------------------------------------------------
  // only the enable bit is stored; the rest of the byte is dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      year_compare_enable_r <= rta_pkg::RST_YEAR_CTL[rta_pkg::BIT_YEAR_EN];
    else if (wr_yc)
      year_compare_enable_r <= bus.wdata[rta_pkg::BIT_YEAR_EN];
  end

  // ------------------------------------------------------------
  // year alarm value
  // ------------------------------------------------------------
  // deliberately outside every reset so the alarm survives them;
  // its content after first power-up is unknown
  always_ff @(posedge clk)
  begin
    if (wr_ya)
      year_alarm_value_r <= bus.wdata;
  end

  // ------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= 16'h0000;
    else if (bus.rd)
    begin
      case (bus.addr)
        rta_pkg::OFS_CTRL_ONE:
          rdata_r <= {8'h00, carry_flag_r, 2'b00, carry_irq_enable_r,
                      alarm_irq_enable_r, 2'b00, alarm_flag_r};
        rta_pkg::OFS_CTRL_TWO:
          rdata_r <= {8'h00, periodic_flag_r, period_select_r, osc_enable_r,
                      2'b00, count_start_r};
        rta_pkg::OFS_YEAR_CTL:
          rdata_r <= {8'h00, year_compare_enable_r, 7'h00};
        rta_pkg::OFS_YEAR_ALRM:
          rdata_r <= year_alarm_value_r;
        default:
          rdata_r <= 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  // plain levels, one cycle behind the flags; clearing either the flag
  // or the enable drops the request on the next edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alarm_irq_r    <= 1'b0;
      periodic_irq_r <= 1'b0;
      carry_irq_r    <= 1'b0;
    end
    else
    begin
      alarm_irq_r    <= alarm_flag_r && alarm_irq_enable_r;
      periodic_irq_r <= (period_select_r != 3'h0) && periodic_flag_r;
      carry_irq_r    <= carry_flag_r && carry_irq_enable_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus.rdata        = rdata_r;
  assign bus.alarm_irq    = alarm_irq_r;
  assign bus.periodic_irq = periodic_irq_r;
  assign bus.carry_irq    = carry_irq_r;
  assign osc_enable       = osc_enable_r;
  assign count_start      = count_start_r;
  assign divider_reset    = divider_reset_r;
  assign adjust_pulse     = adjust_pulse_r;

endmodule // rta_dev

// file: sim/rta_properties.sv
// bus and request checker for the rtc alarm block
`timescale 1ns/1ps
module rta_properties (
  input wire logic        clk,          // clock
  input wire logic        rst_n,        // sync reset, low
  input wire logic [1:0]  addr,         // index
  input wire logic [15:0] wdata,        // write data
  input wire logic        wr,           // write strobe
  input wire logic        rd,           // read strobe
  input wire logic [15:0] rdata,        // read data
  input wire logic        alarm_irq,    // alarm request
  input wire logic        periodic_irq, // periodic request
  input wire logic        carry_irq     // carry request
);
  logic        yen_r;        // year enable shadow
  logic [15:0] ya_r;         // year alarm shadow
  logic        ya_ok = 1'b0; // alarm written once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // year enable shadow follows reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      yen_r <= 1'b0;
    else if (wr && addr == 2'h2)
      yen_r <= wdata[7];
  end
  // year alarm shadow has no reset: contents must outlive it
  always_ff @(posedge clk)
  begin
    if (wr && addr == 2'h3)
    begin
      ya_r  <= wdata;
      ya_ok <= 1'b1;
    end
  end
  AST_YCTL_READ: assert property (rd && addr == 2'h2 |=>
    rdata == {8'h00, yen_r, 7'h00}) else $error("year control readback");
  AST_YALARM_READ: assert property (rd && addr == 2'h3 && ya_ok |=>
    rdata == ya_r) else $error("year alarm readback");
  AST_ALARM_IRQ: assert property (rd && addr == 2'h0 |=>
    alarm_irq == (rdata[0] && rdata[3])) else $error("alarm request level");
  AST_CARRY_IRQ: assert property (rd && addr == 2'h0 |=>
    carry_irq == (rdata[7] && rdata[4])) else $error("carry request level");
  AST_PERIOD_IRQ: assert property (wr && addr == 2'h1 && wdata[6:4] == 3'h0 |->
    ##2 !periodic_irq) else $error("periodic request");
  AST_ALARM_HOLD: assert property ($fell(alarm_irq) |->
    $past(wr && addr == 2'h0, 2)) else $error("alarm request dropped alone");
  AST_CARRY_HOLD: assert property ($fell(carry_irq) |->
    $past(wr && addr == 2'h0, 2)) else $error("carry request dropped alone");
  AST_PERIOD_HOLD: assert property ($fell(periodic_irq) |->
    $past(wr && addr == 2'h1, 2)) else $error("periodic request dropped alone");
  AST_IRQ_RESET: assert property ($rose(rst_n) |->
    !alarm_irq && !periodic_irq && !carry_irq) else $error("request after reset");
endmodule // rta_properties

// file: sim/rtc_alarm_and_interrupts_tb.sv
// self-checking bench for the rtc alarm block and its controller
`timescale 1ns/1ps
module rtc_alarm_and_interrupts_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] year_counter = 16'h2023;
  logic [5:0]  field_enable = 6'h00;
  logic [5:0]  field_match = 6'h01;
  logic        carry_event = 1'b0;
  logic [6:0]  period_tick = 7'h00;
  logic [2:0]  sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [15:0] sw_rdata, st;
  logic        osc_enable, count_start, divider_reset, adjust_pulse;
  int          err_total = 0, comparisons = 0, cyc = 0, dr_cnt = 0, adj_cnt = 0;
  rta_if rif ();
  rta_dev u_rta_dev (.clk(clk), .rst_n(rst_n), .bus(rif), .year_counter(year_counter),
    .field_enable(field_enable), .field_match(field_match), .carry_event(carry_event),
    .period_tick(period_tick), .osc_enable(osc_enable), .count_start(count_start),
    .divider_reset(divider_reset), .adjust_pulse(adjust_pulse));
  rta_host u_rta_host (.clk(clk), .rst_n(rst_n), .bus(rif), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  rta_properties u_rta_properties (.clk(clk), .rst_n(rst_n), .addr(rif.addr),
    .wdata(rif.wdata), .wr(rif.wr), .rd(rif.rd), .rdata(rif.rdata),
    .alarm_irq(rif.alarm_irq), .periodic_irq(rif.periodic_irq), .carry_irq(rif.carry_irq));
  initial
    forever #12.5 clk = ~clk;
  // cycle limit guards against a controller stuck busy
  always @(posedge clk)
  begin
    cyc++;
    if (divider_reset === 1'b1)
      dr_cnt++;
    if (adjust_pulse === 1'b1)
      adj_cnt++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic sw_w(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [2:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 st = sw_rdata;
  endtask
  // issue a command, poll busy under a bound, let requests settle
  task automatic run(input logic [15:0] c);
    sw_w(rta_pkg::HOFS_CMD, c);
    st = 16'h0001;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 60 && st[0] !== 1'b0; i++)
      sw_r(rta_pkg::HOFS_STATUS);
    chk("busy", 16'h0000, st[0]);
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [6:0] t, input logic c);
    @(posedge clk);
    period_tick <= t;
    carry_event <= c;
    @(posedge clk);
    period_tick <= 7'h00;
    carry_event <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_alarm();
    sw_w(rta_pkg::HOFS_C1, 16'h0018);
    sw_w(rta_pkg::HOFS_C2, 16'h0009);
    sw_w(rta_pkg::HOFS_YA, 16'h2024);
    sw_w(rta_pkg::HOFS_YC, 16'h0080);
    st = 16'h0001;
    run(16'h0001);
    chk("divider pulses", 16'h0001, dr_cnt[15:0]);
    chk("alarm year off", 16'h0000, rif.alarm_irq);
    year_counter <= 16'h2024;
    repeat (4) @(posedge clk);
    chk("alarm year on", 16'h0001, rif.alarm_irq);
    run(16'h0001);
    chk("alarm reset", 16'h0001, rif.alarm_irq);
    field_enable <= 6'h03;
    run(16'h0001);
    chk("alarm partial", 16'h0000, rif.alarm_irq);
  endtask
  // carry present when arming forces a rewrite
  task automatic t_carry();
    pulse(7'h00, 1'b1);
    chk("carry on", 16'h0001, rif.carry_irq);
    run(16'h0002);
    chk("retried", 16'h0001, st[2]);
    chk("carry off", 16'h0000, rif.carry_irq);
  endtask
  // an alarm digit above nine is refused before any bus cycle
  task automatic t_bcd();
    sw_w(rta_pkg::HOFS_YA, 16'h20A4);
    sw_w(rta_pkg::HOFS_CMD, 16'h0002);
    sw_r(rta_pkg::HOFS_STATUS);
    chk("bcd refused", 16'h0002, st[1:0]);
    sw_w(rta_pkg::HOFS_YA, 16'h2024);
  endtask
  task automatic t_period();
    for (int k = 1; k < 8; k++)
    begin
      sw_w(rta_pkg::HOFS_C2, {9'h000, k[2:0], 4'h9});
      run(16'h0001);
      pulse(7'h01 << (k % 7), 1'b0);
      chk("period wrong", 16'h0000, rif.periodic_irq);
      pulse(7'h01 << (k - 1), 1'b0);
      chk("period right", 16'h0001, rif.periodic_irq);
    end
    // flag written set with select zero: the request must stay low
    sw_w(rta_pkg::HOFS_C2, 16'h008D);
    run(16'h0001);
    pulse(7'h7F, 1'b0);
    chk("period off", 16'h0000, rif.periodic_irq);
    chk("adjust pulses", 16'h0001, adj_cnt[15:0]);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("osc", 16'h0001, osc_enable);
    chk("start", 16'h0001, count_start);
    t_alarm();
    t_carry();
    t_bcd();
    t_period();
    results();
  end
endmodule // rtc_alarm_and_interrupts_tb
